// ==== bench/src_partner.sv ====
// Partner model: on-chip reset sources as one-hot request pulses.
// Assumes commands change at core_clk rising edges.
`timescale 1ns/1ps
module src_partner (
  // Command
  input  wire logic       fire,
  input  wire logic [3:0] idx,
  // Requests
  output logic      [9:0] req
);
  // One source at a time, active high while fire is held
  assign req = fire ? (10'h001 << idx) : 10'h000;
endmodule // src_partner

// ==== bench/testbench.sv ====
// Self-checking bench of the system reset combiner.
// Assumes the src_pkg package and the design files are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import src_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        fire = 1'b0;
  logic        cause_wr = 1'b0;
  logic        osc_wr = 1'b0;
  logic [3:0]  idx = 4'h0;
  logic [15:0] cause_wdata = 16'h0000;
  logic [2:0]  dflt = 3'h5;
  logic [2:0]  osc_wdata = 3'h0;
  wire  [9:0]  req;
  wire         msr;
  wire  [15:0] cause;
  wire  [2:0]  osc;
  int          error_cnt = 0;
  int          check_count = 0;
  src_partner u_src_partner (.fire(fire), .idx(idx), .req(req));
  src_reset_combiner u_src_reset_combiner (
    .core_clk(core_clk), .rst(rst), .brownout_req(req[0]),
    .external_clear_pin_reset(req[1]), .software_instruction_reset(req[2]),
    .watchdog_timeout_reset(req[3]), .config_mismatch_reset(req[4]),
    .trap_conflict_reset(req[5]), .illegal_condition_reset(req[6]),
    .illegal_opcode_reset(req[7]), .uninit_wreg_reset(req[8]), .security_reset(req[9]),
    .cause_wr(cause_wr), .cause_wdata(cause_wdata), .default_osc_select(dflt),
    .osc_wr(osc_wr), .osc_wdata(osc_wdata), .master_system_reset(msr),
    .reset_cause_register(cause), .new_osc_select_field(osc));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  // Source held for n cycles; master must stand throughout
  task automatic drive_src(input logic [3:0] i, input int n);
    @(posedge core_clk);
    idx <= i;
    fire <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      if (k == n - 1) begin
        fire <= 1'b0;
      end
      #1;
      `CHK("master held", 1'b1, msr)
    end
  endtask
  task automatic wr_cause(input logic [15:0] d);
    @(posedge core_clk);
    cause_wr <= 1'b1;
    cause_wdata <= d;
    @(posedge core_clk);
    cause_wr <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (5) tick();
    `CHK("master in reset", 1'b1, msr)
    `CHK("cause at power-on", CAUSE_POR_VAL, cause)
    `CHK("osc in reset", OSC_RST_VAL, osc)
    @(posedge core_clk);
    rst <= 1'b0;
    tick();
    `CHK("master release", 1'b0, msr)
    `CHK("osc default", dflt, osc)
    `CHK("cause after release", CAUSE_POR_VAL, cause)
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      dflt <= 3'(i + 1);
      wr_cause(16'h0000);
      `CHK("cause cleared", 16'h0000, cause)
      drive_src(4'(i), 1 + i % 3);
      `CHK("cause flag", 16'h0001 << (i + 1), cause)
      tick();
      `CHK("master idle", 1'b0, msr)
      `CHK("osc reload", dflt, osc)
    end
    wr_cause(16'hFFFF);
    `CHK("cause set all", CAUSE_IMPL_MSK, cause)
    tick();
    `CHK("no reset on set", 1'b0, msr)
    @(posedge core_clk);
    osc_wr <= 1'b1;
    osc_wdata <= 3'h6;
    @(posedge core_clk);
    osc_wr <= 1'b0;
    #1;
    `CHK("osc kept", 3'h6, osc)
    @(posedge core_clk);
    osc_wr <= 1'b1;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
    osc_wr <= 1'b0;
    #1;
    `CHK("osc over write", dflt, osc)
    `CHK("cause kept", CAUSE_IMPL_MSK, cause)
    @(posedge core_clk);
    cause_wr <= 1'b1;
    cause_wdata <= 16'h0000;
    fire <= 1'b1;
    @(posedge core_clk);
    cause_wr <= 1'b0;
    fire <= 1'b0;
    #1;
    `CHK("set beats clear", 16'h0001 << BIT_SECURITY, cause)
    `CHK("master on set", 1'b1, msr)
    @(posedge core_clk);
    rst <= 1'b1;
    #1;
    `CHK("cause second por", CAUSE_POR_VAL, cause)
    `CHK("master second por", 1'b1, msr)
    @(posedge core_clk);
    rst <= 1'b0;
    tick();
    `CHK("master after por", 1'b0, msr)
    `CHK("osc after por", dflt, osc)
    complete_run();
  end
endmodule // testbench

// ==== design/src_flag_bank.sv ====
// Bank of sticky status flags with hardware set and software write.
// Assumes set inputs and write strobe are synchronous to clk.
`timescale 1ns/1ps
module src_flag_bank #(
  parameter int                  N       = 16,
  parameter logic [N-1:0]        RST_VAL = '0,
  parameter logic [N-1:0]        IMPL    = '1
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Hardware set
  input  wire logic [N-1:0]  set,
  // Software write
  input  wire logic          wr,
  input  wire logic [N-1:0]  wdata,
  // Flags
  output logic      [N-1:0]  flags
);

  logic [N-1:0] next_flags;

  // ************************************************************
  // Per-bit next value: set beats a software clear
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign next_flags[i] = IMPL[i] & (set[i] | (wr ? wdata[i] : flags[i]));
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= RST_VAL;
    end else begin
      flags <= next_flags;
    end
  end

endmodule // src_flag_bank

// ==== design/src_pkg.sv ====
// Shared constants of the system reset combiner.
// Assumes a single core clock domain.
package src_pkg;

  // ************************************************************
  // Cause flag layout
  // ************************************************************
  localparam int CAUSE_W       = 16;
  localparam int NUM_SRC       = 11;
  localparam int BIT_POR       = 0;
  localparam int BIT_BOR       = 1;
  localparam int BIT_EXT_CLR   = 2;
  localparam int BIT_SW_INSTR  = 3;
  localparam int BIT_WDT       = 4;
  localparam int BIT_CFG_MISM  = 5;
  localparam int BIT_TRAP      = 6;
  localparam int BIT_ILL_COND  = 7;
  localparam int BIT_ILL_OP    = 8;
  localparam int BIT_UNINIT_W  = 9;
  localparam int BIT_SECURITY  = 10;

  // ************************************************************
  // Reset values and field widths
  // ************************************************************
  localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL  = 16'h0003;
  localparam logic [CAUSE_W-1:0] CAUSE_IMPL_MSK = 16'h07FF;
  localparam int                 OSC_SEL_W      = 3;
  localparam logic [OSC_SEL_W-1:0] OSC_RST_VAL  = 3'h0;
  localparam logic                 MSR_RST_VAL  = 1'b1;

endpackage

// ==== design/src_reset_combiner.sv ====
// Contract
// - All reset sources merge into one unit
// - Any active source asserts master reset
// - Reset loads some registers, others kept
// - Each reset kind sets its own flag
// - Power-on clears flags, sets bits one, zero
// - Software may set or clear flags anytime; here a clear loses to a source setting that flag in the same cycle
// - Software flag set never causes reset
// - Reset copies default oscillator select to field
//
// System reset combiner: merges reset sources, records causes,
// loads the default oscillator selection on every reset.
// Assumes all source requests are synchronous to core_clk; rst is
// the power-on reset.
`timescale 1ns/1ps
module src_reset_combiner (
  // Clock and power-on reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // Reset requests
  input  wire logic                           brownout_req,
  input  wire logic                           external_clear_pin_reset,
  input  wire logic                           software_instruction_reset,
  input  wire logic                           watchdog_timeout_reset,
  input  wire logic                           config_mismatch_reset,
  input  wire logic                           trap_conflict_reset,
  input  wire logic                           illegal_condition_reset,
  input  wire logic                           illegal_opcode_reset,
  input  wire logic                           uninit_wreg_reset,
  input  wire logic                           security_reset,
  // Cause register software write
  input  wire logic                           cause_wr,
  input  wire logic [src_pkg::CAUSE_W-1:0]    cause_wdata,
  // Oscillator configuration and software write
  input  wire logic [src_pkg::OSC_SEL_W-1:0]  default_osc_select,
  input  wire logic                           osc_wr,
  input  wire logic [src_pkg::OSC_SEL_W-1:0]  osc_wdata,
  // Outputs
  output logic                                master_system_reset,
  output logic      [src_pkg::CAUSE_W-1:0]    reset_cause_register,
  output logic      [src_pkg::OSC_SEL_W-1:0]  new_osc_select_field
);
  import src_pkg::*;

  // ************************************************************
  // Source gathering
  // ************************************************************
  wire logic [CAUSE_W-1:0]   src_vec;
  wire logic                 any_src;
  wire logic                 next_msr;
  wire logic [OSC_SEL_W-1:0] next_osc;

  assign src_vec[BIT_POR]      = 1'b0;
  assign src_vec[BIT_BOR]      = brownout_req;
  assign src_vec[BIT_EXT_CLR]  = external_clear_pin_reset;
  assign src_vec[BIT_SW_INSTR] = software_instruction_reset;
  assign src_vec[BIT_WDT]      = watchdog_timeout_reset;
  assign src_vec[BIT_CFG_MISM] = config_mismatch_reset;
  assign src_vec[BIT_TRAP]     = trap_conflict_reset;
  assign src_vec[BIT_ILL_COND] = illegal_condition_reset;
  assign src_vec[BIT_ILL_OP]   = illegal_opcode_reset;
  assign src_vec[BIT_UNINIT_W] = uninit_wreg_reset;
  assign src_vec[BIT_SECURITY] = security_reset;
  assign src_vec[CAUSE_W-1:NUM_SRC] = '0;

  assign any_src  = |src_vec;
  // Master reset only from sources, never from a cause write
  assign next_msr = any_src;
  // Reset load wins over a software write
  assign next_osc = master_system_reset ? default_osc_select
                  : (osc_wr ? osc_wdata : new_osc_select_field);

  // ************************************************************
  // Master reset and oscillator field
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      master_system_reset  <= MSR_RST_VAL;
      new_osc_select_field <= OSC_RST_VAL;
    end else begin
      master_system_reset  <= next_msr;
      new_osc_select_field <= next_osc;
    end
  end

  // ************************************************************
  // Cause flags
  // ************************************************************
  src_flag_bank #(
    .N       (CAUSE_W),
    .RST_VAL (CAUSE_POR_VAL),
    .IMPL    (CAUSE_IMPL_MSK)
  ) u_flags (
    .clk   (core_clk),
    .rst   (rst),
    .set   (src_vec),
    .wr    (cause_wr),
    .wdata (cause_wdata),
    .flags (reset_cause_register)
  );

  // ************************************************************
  // Check helpers
  // ************************************************************
  // Checks wait for the first edge that runs out of reset
  logic      seen_clk;
  wire logic checks_off;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_clk <= 1'b0;
    end else begin
      seen_clk <= 1'b1;
    end
  end

  assign checks_off = rst | ~seen_clk;

  sequence src_active_s;
    any_src;
  endsequence

  sequence msr_high_s;
    master_system_reset;
  endsequence

  sequence src_drop_s;
    any_src ##1 !any_src;
  endsequence

  sequence msr_release_s;
    master_system_reset ##1 !master_system_reset;
  endsequence

  sequence sw_only_write_s;
    cause_wr && !any_src;
  endsequence

  sequence osc_sw_write_s;
    osc_wr && !master_system_reset;
  endsequence

  property combine_p;
    @(posedge core_clk) disable iff (checks_off)
      src_active_s |=> msr_high_s;
  endproperty

  property release_p;
    @(posedge core_clk) disable iff (checks_off)
      src_drop_s |-> msr_release_s;
  endproperty

  property sw_write_p;
    @(posedge core_clk) disable iff (checks_off)
      sw_only_write_s |=> reset_cause_register == ($past(cause_wdata) & CAUSE_IMPL_MSK);
  endproperty

  property osc_write_p;
    @(posedge core_clk) disable iff (checks_off)
      osc_sw_write_s |=> new_osc_select_field == $past(osc_wdata);
  endproperty

  // ************************************************************
  // Master reset checks
  // ************************************************************
  combine_sources_a: assert property (combine_p)
    else $error("source did not reach master reset");

  reset_hold_a: assert property (@(posedge core_clk) disable iff (checks_off)
    any_src [*2] |-> master_system_reset [*2])
    else $error("master reset dropped while source active");

  reset_release_a: assert property (@(posedge core_clk) disable iff (checks_off)
    $fell(master_system_reset) |-> $past(!any_src))
    else $error("master reset released with source active");

  release_timing_a: assert property (release_p)
    else $error("master reset not released one cycle after sources");

  idle_release_a: assert property (@(posedge core_clk) disable iff (checks_off)
    !any_src |=> !master_system_reset)
    else $error("master reset held with no source");

  sw_no_reset_a: assert property (@(posedge core_clk) disable iff (checks_off)
    cause_wr && !any_src && !master_system_reset |=> !master_system_reset)
    else $error("cause write triggered a reset");

  // ************************************************************
  // Cause flag checks
  // ************************************************************
  cause_set_a: assert property (@(posedge core_clk) disable iff (checks_off)
    any_src |=> ((reset_cause_register & $past(src_vec)) == $past(src_vec)))
    else $error("cause flag not set by its source");

  unused_bits_a: assert property (@(posedge core_clk) disable iff (checks_off)
    reset_cause_register[CAUSE_W-1:NUM_SRC] == '0)
    else $error("unimplemented cause bit set");

  por_value_a: assert property (@(posedge core_clk) disable iff (checks_off)
    !seen_clk && !cause_wr |=> reset_cause_register == (CAUSE_POR_VAL | $past(src_vec)))
    else $error("power-on cause value wrong");

  por_bit_sw_a: assert property (@(posedge core_clk) disable iff (checks_off)
    !cause_wr |=> !$rose(reset_cause_register[BIT_POR]))
    else $error("power-on flag set outside power-on");

  sw_write_a: assert property (sw_write_p)
    else $error("software write to cause flags lost");

  write_mix_a: assert property (@(posedge core_clk) disable iff (checks_off)
    cause_wr |=> (reset_cause_register & ~$past(src_vec))
                 == ($past(cause_wdata) & CAUSE_IMPL_MSK & ~$past(src_vec)))
    else $error("software write lost beside a source");

  // ************************************************************
  // Oscillator checks
  // ************************************************************
  osc_load_a: assert property (@(posedge core_clk) disable iff (checks_off)
    master_system_reset |=> new_osc_select_field == $past(default_osc_select))
    else $error("oscillator default not loaded on reset");

  osc_keep_a: assert property (@(posedge core_clk) disable iff (checks_off)
    !master_system_reset && !osc_wr |=> $stable(new_osc_select_field))
    else $error("oscillator field changed without cause");

  osc_write_a: assert property (osc_write_p)
    else $error("oscillator software write lost");

endmodule // src_reset_combiner
